// file: hdl/thermo_filter_params.svh
`ifndef THERMO_FILTER_PARAMS_SVH
`define THERMO_FILTER_PARAMS_SVH

// Sensor configuration register fields
`define CFG_TYPE_MSB     6
`define CFG_TYPE_LSB     4
`define CFG_COEF_MSB     2
`define CFG_COEF_LSB     0
`define CFG_IMPL_MASK    8'h77
`define CFG_RESET        8'h00

// Measurement status register fields
`define STAT_UPDATE_BIT  6
`define STAT_ALERT_MSB   3
`define STAT_ALERT_LSB   0
`define STAT_RESET       8'h00

// Temperature datapath
`define TEMP_RESET       16'h0000
`define ACC_RESET        24'h000000
`define LIMIT_IMPL_MASK  16'hFFFC
`define FRAC_BITS        8

`endif

// file: hdl/thermo_filter_pkg.sv
`default_nettype none
package thermo_filter_pkg;

   // Thermocouple type select encoding
   typedef enum logic [2:0] {
      TC_K,
      TC_J,
      TC_T,
      TC_N,
      TC_S,
      TC_E,
      TC_B,
      TC_R
   } tc_type_e;

   // Alert setup: four limits and per-alert junction select
   typedef struct packed {
      logic [3:0][15:0] limit;
      logic [3:0]       use_cold;
   } alert_cfg_s;

   // Whole state of the top module
   typedef struct packed {
      logic [7:0]  cfg;
      logic [7:0]  status;
      logic [15:0] hot;
      logic [23:0] acc;
      logic        primed;
      logic [15:0] delta;
      logic        sample_pulse;
   } state_s;

endpackage
`default_nettype wire

// file: hdl/ema_step.sv
`timescale 1ns/1ps
`default_nettype none
`include "thermo_filter_params.svh"

// One step of the exponential average, Y = Y1 + 2(X - Y1)/(2^n + 1)
module ema_step
   import thermo_filter_pkg::*;
(
   input  wire logic [15:0] sample_i,   // New hot-junction sample
   input  wire logic [23:0] prev_i,     // Previous output, fixed point
   input  wire logic [2:0]  coef_i,     // Filter coefficient n
   input  wire logic        primed_i,   // Previous output is valid
   output logic      [23:0] next_o      // New output, fixed point
);

   logic signed [24:0] x_fix;
   logic signed [24:0] diff;
   logic signed [25:0] num;
   logic signed [9:0]  den;
   logic signed [25:0] step;

   // Rule arithmetic in sign-extended fixed point
   always_comb begin
      x_fix = 25'($signed({sample_i, {`FRAC_BITS{1'b0}}}));
      diff  = x_fix - 25'($signed(prev_i));
      num   = 26'(diff) <<< 1;
      den   = 10'((10'd1 << coef_i) + 10'd1);
      step  = num / 26'(den);
      if (!primed_i) begin
         next_o = x_fix[23:0];
      end else if (coef_i == 3'h0) begin
         next_o = x_fix[23:0];
      end else begin
         next_o = 24'($signed(prev_i) + step);
      end
   end

endmodule
`default_nettype wire

// file: hdl/thermo_filter_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "thermo_filter_params.svh"

// Notes on behaviour
// - status bit 0 high when selected temperature exceeds first limit.
// - bits 1..3 do same for limits two..four; writes ignored.
// - each alert compares hot or cold junction, chosen per alert.
// - config bits 6..4 pick type K,J,T,N,S,E,B,R.
// - coefficient set of the selected type is applied in conversion.
// - filter is first order, from new sample and previous output.
// - output is k*X + (1-k)*Y1, k = 2/(2^n+1).
// - filter input is the unfiltered hot-junction temperature.
// - filtered result goes into the delta temperature register.
// - config bits 2..0 give n; zero turns filtering off.
// - any write of sensor configuration resets the filter.
// - config bits 7 and 3 always read zero.
// - status bit 6 set per conversion; software may clear it.
module thermo_filter_status
   import thermo_filter_pkg::*;
(
   input  wire logic        clk_i,            // 125 MHz clock
   input  wire logic        rst_b_i,          // Sync reset, active low
   input  wire logic        cfg_wr_i,         // Sensor config write strobe
   input  wire logic [7:0]  cfg_wdata_i,      // Sensor config write data
   input  wire logic        status_wr_i,      // Status write strobe
   input  wire logic [7:0]  status_wdata_i,   // Status write data
   input  wire logic        sample_valid_i,   // Conversion complete pulse
   input  wire logic [15:0] hot_sample_i,     // Unfiltered hot junction
   input  wire logic [15:0] cold_temp_i,      // Cold-junction register
   input  wire alert_cfg_s  alert_cfg_i,      // Alert limits and selects
   output logic      [7:0]  sensor_config_o,  // Sensor config read value
   output logic      [7:0]  status_o,         // Status read value
   output logic      [15:0] hot_temp_o,       // Hot-junction register
   output logic      [15:0] delta_temp_o,     // Filtered temperature
   output var tc_type_e     tc_type_o,        // Coefficient set select
   output logic             sample_done_o     // Filter update pulse
);

   state_s      state_reg;
   state_s      state_next;
   logic [23:0] ema_next;
   logic [3:0]  alert_hit;

   // Junction chosen for one alert
   function automatic logic [15:0] pick_temp(input logic        use_cold,
                                             input logic [15:0] hot,
                                             input logic [15:0] cold);
      pick_temp = use_cold ? cold : hot;
   endfunction

   // Signed strict greater-than against a limit with low bits unused
   function automatic logic above_limit(input logic [15:0] temp,
                                        input logic [15:0] limit);
      above_limit = $signed(temp) > $signed(limit & `LIMIT_IMPL_MASK);
   endfunction

   // Filter arithmetic for the next state
   ema_step u_ema_step (
      .sample_i (hot_sample_i),
      .prev_i   (state_reg.acc),
      .coef_i   (state_reg.cfg[`CFG_COEF_MSB:`CFG_COEF_LSB]),
      .primed_i (state_reg.primed),
      .next_o   (ema_next)
   );

   // Alert comparisons, one per limit
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         alert_hit[i] = above_limit(
            pick_temp(alert_cfg_i.use_cold[i],
                      state_reg.hot, cold_temp_i),
            alert_cfg_i.limit[i]);
      end
   end

   // Next-state computation
   always_comb begin
      state_next              = state_reg;
      state_next.sample_pulse = 1'b0;

      // Config write; unimplemented bits dropped
      if (cfg_wr_i) begin
         state_next.cfg    = cfg_wdata_i & `CFG_IMPL_MASK;
         state_next.primed = 1'b0;
      end

      // New conversion result
      if (sample_valid_i) begin
         state_next.hot = hot_sample_i;
         if (!cfg_wr_i) begin
            state_next.acc          = ema_next;
            state_next.primed       = 1'b1;
            state_next.delta        = ema_next[23:`FRAC_BITS];
            state_next.sample_pulse = 1'b1;
         end
      end

      // Alert flags track comparisons; writes never touch them
      state_next.status[`STAT_ALERT_MSB:`STAT_ALERT_LSB] =
         alert_hit;

      // Update flag: write one clears, new conversion wins
      if (status_wr_i && status_wdata_i[`STAT_UPDATE_BIT]) begin
         state_next.status[`STAT_UPDATE_BIT] = 1'b0;
      end
      if (sample_valid_i) begin
         state_next.status[`STAT_UPDATE_BIT] = 1'b1;
      end

      // Reset
      if (!rst_b_i) begin
         state_next.cfg          = `CFG_RESET;
         state_next.status       = `STAT_RESET;
         state_next.hot          = `TEMP_RESET;
         state_next.acc          = `ACC_RESET;
         state_next.primed       = 1'b0;
         state_next.delta        = `TEMP_RESET;
         state_next.sample_pulse = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      state_reg <= state_next;
   end

   // Outputs straight from the state flops
   always_comb begin
      sensor_config_o = state_reg.cfg;
      status_o        = state_reg.status;
      hot_temp_o      = state_reg.hot;
      delta_temp_o    = state_reg.delta;
      tc_type_o       = tc_type_e'(
         state_reg.cfg[`CFG_TYPE_MSB:`CFG_TYPE_LSB]);
      sample_done_o   = state_reg.sample_pulse;
   end

   // tc_type_o steers the converter's correction coefficients

endmodule
`default_nettype wire

// file: bench/thermo_filter_status_properties.sv
`timescale 1ns/1ps
`default_nettype none
module thermo_filter_status_properties
   import thermo_filter_pkg::*;
(
   input wire logic        clk_i, rst_b_i, cfg_wr_i, status_wr_i,
   input wire logic        sample_valid_i, sample_done_o,
   input wire logic [7:0]  cfg_wdata_i, status_wdata_i,
   input wire logic [7:0]  sensor_config_o, status_o,
   input wire logic [15:0] hot_sample_i, cold_temp_i,
   input wire logic [15:0] hot_temp_o, delta_temp_o,
   input wire alert_cfg_s  alert_cfg_i,
   input wire tc_type_e    tc_type_o
);
   logic [3:0] gt;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // Expected alert flags from the selected junction
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         gt[i] = $signed(alert_cfg_i.use_cold[i] ? cold_temp_i : hot_temp_o)
            > $signed(alert_cfg_i.limit[i] & 16'hFFFC);
      end
   end
   property p_cfg; cfg_wr_i |=>
      sensor_config_o == ($past(cfg_wdata_i) & 8'h77); endproperty
   a_cfg: assert property (p_cfg) else $error("cfg readback");
   property p_typ; cfg_wr_i |=> tc_type_o == $past(cfg_wdata_i[6:4]);
   endproperty
   a_typ: assert property (p_typ) else $error("type select");
   property p_zero; sample_valid_i && !cfg_wr_i && sensor_config_o[2:0] == 3'h0
      |=> delta_temp_o == $past(hot_sample_i); endproperty
   a_zero: assert property (p_zero) else $error("n0 pass");
   property p_done; sample_valid_i && !cfg_wr_i |=> sample_done_o; endproperty
   a_done: assert property (p_done) else $error("no done");
   property p_nod; cfg_wr_i |=> !sample_done_o; endproperty
   a_nod: assert property (p_nod) else $error("filter reset");
   property p_hot; sample_valid_i |=> hot_temp_o == $past(hot_sample_i);
   endproperty
   a_hot: assert property (p_hot) else $error("hot value");
   property p_upd; sample_valid_i |=> status_o[6]; endproperty
   a_upd: assert property (p_upd) else $error("flag set");
   property p_clr; status_wr_i && status_wdata_i[6] && !sample_valid_i
      |=> !status_o[6]; endproperty
   a_clr: assert property (p_clr) else $error("flag clear");
   property p_alr; 1'b1 |=> status_o[3:0] == $past(gt); endproperty
   a_alr: assert property (p_alr) else $error("alert flags");
endmodule
bind thermo_filter_status thermo_filter_status_properties chk (
   .clk_i           (clk_i),
   .rst_b_i         (rst_b_i),
   .cfg_wr_i        (cfg_wr_i),
   .status_wr_i     (status_wr_i),
   .sample_valid_i  (sample_valid_i),
   .sample_done_o   (sample_done_o),
   .cfg_wdata_i     (cfg_wdata_i),
   .status_wdata_i  (status_wdata_i),
   .sensor_config_o (sensor_config_o),
   .status_o        (status_o),
   .hot_sample_i    (hot_sample_i),
   .cold_temp_i     (cold_temp_i),
   .hot_temp_o      (hot_temp_o),
   .delta_temp_o    (delta_temp_o),
   .alert_cfg_i     (alert_cfg_i),
   .tc_type_o       (tc_type_o)
);
`default_nettype wire

// file: bench/thermo_filter_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module thermo_filter_status_tb
   import thermo_filter_pkg::*;
;
   logic       clk_i = 1'b0, rst_b_i = 1'b0, cfg_wr_i = 1'b0;
   logic       status_wr_i = 1'b0, sample_valid_i = 1'b0, sample_done_o;
   logic [7:0] cfg_wdata_i = 8'h00, status_wdata_i = 8'h00;
   logic [7:0] sensor_config_o, status_o;
   logic [15:0] hot_sample_i = 16'h0000, cold_temp_i = 16'h0300;
   logic [15:0] hot_temp_o, delta_temp_o;
   alert_cfg_s alert_cfg_i = '{limit: {16'hFF00, 16'h0303, 16'h0200,
      16'h0100}, use_cold: 4'b1100};
   tc_type_e   tc_type_o;
   int         failures = 0, n_checks = 0;
   always #4 clk_i = ~clk_i;
   thermo_filter_status DUT (
      .clk_i           (clk_i),
      .rst_b_i         (rst_b_i),
      .cfg_wr_i        (cfg_wr_i),
      .cfg_wdata_i     (cfg_wdata_i),
      .status_wr_i     (status_wr_i),
      .status_wdata_i  (status_wdata_i),
      .sample_valid_i  (sample_valid_i),
      .hot_sample_i    (hot_sample_i),
      .cold_temp_i     (cold_temp_i),
      .alert_cfg_i     (alert_cfg_i),
      .sensor_config_o (sensor_config_o),
      .status_o        (status_o),
      .hot_temp_o      (hot_temp_o),
      .delta_temp_o    (delta_temp_o),
      .tc_type_o       (tc_type_o),
      .sample_done_o   (sample_done_o)
   );
   // Strobe tasks, one cycle each, driven at falling edges
   task automatic wr_cfg(input logic [7:0] d);
      @(negedge clk_i);
      cfg_wdata_i = d;
      cfg_wr_i = 1'b1;
      @(negedge clk_i);
      cfg_wr_i = 1'b0;
   endtask
   task automatic wr_st(input logic [7:0] d);
      @(negedge clk_i);
      status_wdata_i = d;
      status_wr_i = 1'b1;
      @(negedge clk_i);
      status_wr_i = 1'b0;
   endtask
   task automatic smp(input logic [15:0] x);
      @(negedge clk_i);
      hot_sample_i = x;
      sample_valid_i = 1'b1;
      @(negedge clk_i);
      sample_valid_i = 1'b0;
   endtask
   task automatic wrap_up;
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (10) @(negedge clk_i);
      `CHK(sensor_config_o, 8'h00)
      `CHK(status_o, 8'h00)
      rst_b_i = 1'b1;
      for (int t = 0; t < 8; t++) begin
         wr_cfg({1'b1, t[2:0], 4'hF});
         `CHK(sensor_config_o, {1'b0, t[2:0], 4'h7})
         `CHK(tc_type_o, tc_type_e'(t[2:0]))
      end
      $display("test config done");
      wr_cfg(8'h00);
      smp(16'h0123);
      `CHK(delta_temp_o, 16'h0123)
      `CHK(sample_done_o, 1'b1)
      smp(16'hFF00);
      `CHK(delta_temp_o, 16'hFF00)
      `CHK(hot_temp_o, 16'hFF00)
      $display("test passthrough done");
      wr_cfg(8'h01);
      smp(16'h0100);
      `CHK(delta_temp_o, 16'h0100)
      smp(16'h0400);
      `CHK(delta_temp_o, 16'h0300)
      wr_cfg(8'h02);
      smp(16'h0000);
      smp(16'h0500);
      `CHK(delta_temp_o, 16'h0200)
      smp(16'h0500);
      `CHK(delta_temp_o, 16'h0333)
      wr_cfg(8'h02);
      smp(16'h0050);
      `CHK(delta_temp_o, 16'h0050)
      $display("test filter done");
      smp(16'h0150);
      @(negedge clk_i);
      `CHK(status_o, 8'h49)
      wr_st(8'h0F);
      `CHK(status_o, 8'h49)
      wr_st(8'h40);
      `CHK(status_o, 8'h09)
      cold_temp_i = 16'h0304;
      @(negedge clk_i);
      `CHK(status_o[3:0], 4'hD)
      $display("test status done");
      // Sample, flag clear and config write in one cycle
      @(negedge clk_i);
      hot_sample_i = 16'h0200;
      sample_valid_i = 1'b1;
      status_wdata_i = 8'h40;
      status_wr_i = 1'b1;
      cfg_wdata_i = 8'h02;
      cfg_wr_i = 1'b1;
      @(negedge clk_i);
      sample_valid_i = 1'b0;
      status_wr_i = 1'b0;
      cfg_wr_i = 1'b0;
      `CHK(status_o[6], 1'b1)
      `CHK(hot_temp_o, 16'h0200)
      `CHK(delta_temp_o, 16'h00B6)
      `CHK(sample_done_o, 1'b0)
      smp(16'h0400);
      `CHK(delta_temp_o, 16'h0400)
      $display("test collision done");
      // Reset in mid-run, then a fresh sample
      rst_b_i = 1'b0;
      repeat (2) @(negedge clk_i);
      `CHK(sensor_config_o, 8'h00)
      `CHK(delta_temp_o, 16'h0000)
      `CHK(status_o, 8'h00)
      rst_b_i = 1'b1;
      smp(16'h0080);
      `CHK(delta_temp_o, 16'h0080)
      `CHK(sample_done_o, 1'b1)
      $display("test reset done");
      wrap_up();
   end
endmodule
`default_nettype wire
